/* File: src/ascc_pkg.sv */
// constants for the audio serial clock and buffer configuration block
// assumes one 25 MHz system clock and a plain register port
package ascc_pkg;

  // register offsets (byte addresses)
  localparam logic [11:0] OFS_MCLK_EN   = 12'h510;
  localparam logic [11:0] OFS_MCLK_DIV  = 12'h514;
  localparam logic [11:0] OFS_RATIO     = 12'h518;
  localparam logic [11:0] OFS_WIDTH     = 12'h51C;
  localparam logic [11:0] OFS_ALIGN     = 12'h520;
  localparam logic [11:0] OFS_FORMAT    = 12'h524;
  localparam logic [11:0] OFS_CHANNELS  = 12'h528;
  localparam logic [11:0] OFS_RX_START  = 12'h538;
  localparam logic [11:0] OFS_TX_START  = 12'h540;
  localparam logic [11:0] OFS_WORD_CNT  = 12'h550;
  localparam logic [11:0] OFS_STATUS    = 12'h600;
  localparam logic [11:0] OFS_RX_INDEX  = 12'h604;
  localparam logic [11:0] OFS_TX_INDEX  = 12'h608;

  // values after reset
  localparam logic [31:0] RST_MCLK_EN   = 32'h0000_0001;
  localparam logic [31:0] RST_MCLK_DIV  = 32'h2000_0000;
  localparam logic [3:0]  RST_RATIO     = 4'h6;
  localparam logic [31:0] RST_CFG_WORD  = 32'h0000_0000;
  localparam logic [1:0]  RST_CHANNELS  = 2'h0;
  localparam logic [31:0] RST_POINTER   = 32'h0000_0000;
  localparam logic [31:0] RST_WORD_CNT  = 32'h0000_0000;

  // master clock frequency codes (fraction of 2^32 per source cycle)
  localparam logic [31:0] DIVIDE_BY_EIGHT_CODE = 32'h2000_0000;
  localparam logic [31:0] DIVIDE_BY_125_CODE   = 32'h020C_0000;

  // frame clock ratio codes and channel codes
  localparam logic [3:0]  RATIO_256_CODE = 4'h6;
  localparam logic [1:0]  CHAN_STEREO    = 2'h0;
  localparam logic [1:0]  CHAN_LEFT      = 2'h1;
  localparam logic [1:0]  CHAN_RIGHT     = 2'h2;

  // field positions
  localparam int RATIO_MSB    = 3;
  localparam int CHANNELS_MSB = 1;
  localparam int ALIGN_LSB    = 2;

  // status bit positions
  localparam int ST_MCLK_RUN  = 0;
  localparam int ST_MCLK_LVL  = 1;
  localparam int ST_FRAME_LVL = 2;
  localparam int ST_TX_BUSY   = 3;

  // half period of the frame clock, in master clock cycles, minus one
  function automatic logic [7:0] ascc_half_m1(input logic [3:0] code);
    case (code)
      4'h0:    ascc_half_m1 = 8'h0F;
      4'h1:    ascc_half_m1 = 8'h17;
      4'h2:    ascc_half_m1 = 8'h1F;
      4'h3:    ascc_half_m1 = 8'h2F;
      4'h4:    ascc_half_m1 = 8'h3F;
      4'h5:    ascc_half_m1 = 8'h5F;
      4'h6:    ascc_half_m1 = 8'h7F;
      4'h7:    ascc_half_m1 = 8'hBF;
      4'h8:    ascc_half_m1 = 8'hFF;
      default: ascc_half_m1 = 8'h7F;
    endcase
  endfunction

  typedef enum logic [1:0] {
    TXF_IDLE = 2'b01,
    TXF_WAIT = 2'b10
  } ascc_txf_t;

endpackage

/* File: src/ascc_top.sv */
// audio serial clock, ratio, channel and buffer pointer configuration
// assumes framing logic outside asks for and hands over whole words
//
// What this block does
// - phase accumulator master clock; reset code 0x20000000 divides by 8
// - codes for divide by 10, 11, 15, 16, 21 and 23 all work
// - codes for divide by 31, 42, 63 and 125 work; any code accepted
// - receive pointer is receive buffer start address; resets to zero
// - transmit words are fetched starting at the transmit pointer
// - transmit pointer used word aligned; only whole 32-bit reads
// - enable 0 stops the generator and releases the pin; 1 drives it
// - one word count sizes both receive and transmit buffers
`timescale 1ns/100ps

module ascc_top (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // register port
  input  wire logic [11:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output      logic [31:0] o_rdata,
  // audio clocks toward the codec
  output      logic        o_master_clock_out,
  output      logic        o_master_clock_oe,
  output      logic        o_frame_clock,
  output      logic        o_frame_tick,
  // configuration toward the framing logic
  output      logic        o_left_en,
  output      logic        o_right_en,
  output      logic [31:0] o_sample_width_setting,
  output      logic [31:0] o_align_setting,
  output      logic [31:0] o_format_setting,
  // received words from the framing logic
  input  wire logic        i_rx_word_valid,
  input  wire logic [31:0] i_rx_word,
  // receive memory write port
  output      logic        o_rxm_wr,
  output      logic [31:0] o_rxm_addr,
  output      logic [31:0] o_rxm_wdata,
  // transmit word request from the framing logic
  input  wire logic        i_tx_req,
  output      logic        o_tx_ready,
  output      logic        o_tx_word_valid,
  output      logic [31:0] o_tx_word,
  // transmit memory read port
  output      logic        o_txm_rd,
  output      logic [31:0] o_txm_addr,
  input  wire logic        i_txm_rvalid,
  input  wire logic [31:0] i_txm_rdata
);
  import ascc_pkg::*;

  logic        mclk_en_ff;
  logic [31:0] mclk_div_ff;
  logic [3:0]  ratio_ff;
  logic [31:0] width_ff;
  logic [31:0] align_ff;
  logic [31:0] format_ff;
  logic [1:0]  channels_ff;
  logic [29:0] rx_start_ff;
  logic [29:0] tx_start_ff;
  logic [31:0] word_cnt_ff;
  logic [31:0] acc_ff;
  logic [31:0] nxt_acc;
  logic        mclk_rise;
  logic [7:0]  half_cnt_ff;
  logic        frame_ff;
  logic        frame_tick_ff;
  logic [31:0] rx_idx_ff;
  logic [31:0] tx_idx_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        rxm_wr_ff;
  logic [31:0] rxm_addr_ff;
  logic [31:0] rxm_wdata_ff;
  logic        txm_rd_ff;
  logic [31:0] txm_addr_ff;
  logic        tx_valid_ff;
  logic [31:0] tx_word_ff;
  ascc_txf_t   txf_ff;
  ascc_txf_t   nxt_txf;

  function automatic logic [31:0] wrap_next(input logic [31:0] idx,
                                            input logic [31:0] cnt);
    if (cnt == 32'h0000_0000 || idx + 32'h0000_0001 >= cnt) begin
      wrap_next = 32'h0000_0000;
    end else begin
      wrap_next = idx + 32'h0000_0001;
    end
  endfunction

  // register writes, one block per setting
  // enable resets on, so the master clock pin is driven out of reset
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mclk_en_ff <= RST_MCLK_EN[0];
    end else if (i_wr && i_addr == OFS_MCLK_EN) begin
      mclk_en_ff <= i_wdata[0];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mclk_div_ff <= RST_MCLK_DIV;
    end else if (i_wr && i_addr == OFS_MCLK_DIV) begin
      mclk_div_ff <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ratio_ff <= RST_RATIO;
    end else if (i_wr && i_addr == OFS_RATIO) begin
      ratio_ff <= i_wdata[RATIO_MSB:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      width_ff <= RST_CFG_WORD;
    end else if (i_wr && i_addr == OFS_WIDTH) begin
      width_ff <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      align_ff <= RST_CFG_WORD;
    end else if (i_wr && i_addr == OFS_ALIGN) begin
      align_ff <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      format_ff <= RST_CFG_WORD;
    end else if (i_wr && i_addr == OFS_FORMAT) begin
      format_ff <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      channels_ff <= RST_CHANNELS;
    end else if (i_wr && i_addr == OFS_CHANNELS) begin
      channels_ff <= i_wdata[CHANNELS_MSB:0];
    end
  end

  // low two bits dropped: a pointer always names a whole word
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_start_ff <= RST_POINTER[31:2];
    end else if (i_wr && i_addr == OFS_RX_START) begin
      rx_start_ff <= i_wdata[31:ALIGN_LSB];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_start_ff <= RST_POINTER[31:2];
    end else if (i_wr && i_addr == OFS_TX_START) begin
      tx_start_ff <= i_wdata[31:ALIGN_LSB];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      word_cnt_ff <= RST_WORD_CNT;
    end else if (i_wr && i_addr == OFS_WORD_CNT) begin
      word_cnt_ff <= i_wdata;
    end
  end

  // phase accumulator: the top bit is the master clock
  // any code works, so every listed divide setting is reached
  assign nxt_acc   = acc_ff + mclk_div_ff;
  assign mclk_rise = mclk_en_ff & ~acc_ff[31] & nxt_acc[31];

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_ff <= 32'h0000_0000;
    end else if (!mclk_en_ff) begin
      acc_ff <= 32'h0000_0000;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  // frame clock counts master clock rising edges
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      half_cnt_ff   <= 8'h00;
      frame_ff      <= 1'b0;
      frame_tick_ff <= 1'b0;
    end else if (!mclk_en_ff) begin
      half_cnt_ff   <= 8'h00;
      frame_ff      <= 1'b0;
      frame_tick_ff <= 1'b0;
    end else begin
      frame_tick_ff <= 1'b0;
      if (mclk_rise) begin
        // a ratio change takes effect in the half period already in progress
        if (half_cnt_ff >= ascc_half_m1(ratio_ff)) begin
          half_cnt_ff   <= 8'h00;
          frame_ff      <= ~frame_ff;
          frame_tick_ff <= ~frame_ff;
        end else begin
          half_cnt_ff <= half_cnt_ff + 8'h01;
        end
      end
    end
  end

  // receive path: one memory write per received word
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rxm_wr_ff    <= 1'b0;
      rxm_addr_ff  <= 32'h0000_0000;
      rxm_wdata_ff <= 32'h0000_0000;
      rx_idx_ff    <= 32'h0000_0000;
    end else begin
      rxm_wr_ff <= i_rx_word_valid;
      if (i_rx_word_valid) begin
        rxm_addr_ff  <= {rx_start_ff + rx_idx_ff[29:0], 2'b00};
        rxm_wdata_ff <= i_rx_word;
        rx_idx_ff    <= wrap_next(rx_idx_ff, word_cnt_ff);
      end
    end
  end

  // transmit fetch, one word in flight
  always_comb begin
    nxt_txf = txf_ff;
    case (txf_ff)
      TXF_IDLE: begin
        if (i_tx_req) begin
          nxt_txf = TXF_WAIT;
        end
      end
      TXF_WAIT: begin
        if (i_txm_rvalid) begin
          nxt_txf = TXF_IDLE;
        end
      end
      default: nxt_txf = TXF_IDLE;
    endcase
  end

  assign o_tx_ready = (txf_ff == TXF_IDLE);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      txf_ff <= TXF_IDLE;
    end else begin
      txf_ff <= nxt_txf;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      txm_rd_ff   <= 1'b0;
      txm_addr_ff <= 32'h0000_0000;
      tx_idx_ff   <= 32'h0000_0000;
    end else begin
      txm_rd_ff <= 1'b0;
      if (txf_ff == TXF_IDLE && i_tx_req) begin
        txm_rd_ff   <= 1'b1;
        // low bits forced to zero, so every read is a whole word
        txm_addr_ff <= {tx_start_ff + tx_idx_ff[29:0], 2'b00};
        tx_idx_ff   <= wrap_next(tx_idx_ff, word_cnt_ff);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_valid_ff <= 1'b0;
      tx_word_ff  <= 32'h0000_0000;
    end else begin
      tx_valid_ff <= (txf_ff == TXF_WAIT) & i_txm_rvalid;
      if (txf_ff == TXF_WAIT && i_txm_rvalid) begin
        tx_word_ff <= i_txm_rdata;
      end
    end
  end

  // register reads, unmapped addresses read zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (i_addr)
      OFS_MCLK_EN:  nxt_rdata = {31'h0, mclk_en_ff};
      OFS_MCLK_DIV: nxt_rdata = mclk_div_ff;
      OFS_RATIO:    nxt_rdata = {28'h0, ratio_ff};
      OFS_WIDTH:    nxt_rdata = width_ff;
      OFS_ALIGN:    nxt_rdata = align_ff;
      OFS_FORMAT:   nxt_rdata = format_ff;
      OFS_CHANNELS: nxt_rdata = {30'h0, channels_ff};
      OFS_RX_START: nxt_rdata = {rx_start_ff, 2'b00};
      OFS_TX_START: nxt_rdata = {tx_start_ff, 2'b00};
      OFS_WORD_CNT: nxt_rdata = word_cnt_ff;
      OFS_STATUS: begin
        nxt_rdata[ST_MCLK_RUN]  = mclk_en_ff;
        nxt_rdata[ST_MCLK_LVL]  = acc_ff[31];
        nxt_rdata[ST_FRAME_LVL] = frame_ff;
        nxt_rdata[ST_TX_BUSY]   = (txf_ff == TXF_WAIT);
      end
      OFS_RX_INDEX: nxt_rdata = rx_idx_ff;
      OFS_TX_INDEX: nxt_rdata = tx_idx_ff;
      default:      nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (i_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  // outputs
  assign o_rdata            = rdata_ff;
  assign o_master_clock_out = acc_ff[31] & mclk_en_ff;
  assign o_master_clock_oe  = mclk_en_ff;
  assign o_frame_clock      = frame_ff;
  assign o_frame_tick       = frame_tick_ff;
  // reserved code 3 falls back to stereo
  assign o_left_en  = (channels_ff != CHAN_RIGHT);
  assign o_right_en = (channels_ff != CHAN_LEFT);
  assign o_sample_width_setting = width_ff;
  assign o_align_setting        = align_ff;
  assign o_format_setting       = format_ff;
  assign o_rxm_wr        = rxm_wr_ff;
  assign o_rxm_addr      = rxm_addr_ff;
  assign o_rxm_wdata     = rxm_wdata_ff;
  assign o_txm_rd        = txm_rd_ff;
  assign o_txm_addr      = txm_addr_ff;
  assign o_tx_word_valid = tx_valid_ff;
  assign o_tx_word       = tx_word_ff;

endmodule

/* File: verification/ascc_monitor.sv */
// port assertions for the audio serial configuration block
// assumes one clock domain, reset active low, bound onto ascc_top
`timescale 1ns/100ps

module ascc_monitor
  import ascc_pkg::*;
(
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_resetn,
  // register port
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  // clocks and channels
  input wire logic        o_master_clock_out,
  input wire logic        o_master_clock_oe,
  input wire logic        o_left_en,
  input wire logic        o_right_en,
  // memory side
  input wire logic        i_rx_word_valid,
  input wire logic [31:0] i_rx_word,
  input wire logic        o_rxm_wr,
  input wire logic [31:0] o_rxm_wdata,
  input wire logic        i_tx_req,
  input wire logic        o_tx_ready,
  input wire logic        o_tx_word_valid,
  input wire logic [31:0] o_tx_word,
  input wire logic        o_txm_rd,
  input wire logic [31:0] o_txm_addr,
  input wire logic        i_txm_rvalid,
  input wire logic [31:0] i_txm_rdata
);
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_rdata_idle_zero: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  a_mclk_start_low: assert property (
    !o_master_clock_oe ##1 o_master_clock_oe |-> !o_master_clock_out)
    else $error("master clock not restarted from low");
  a_oe_from_write: assert property (
    i_wr && i_addr == OFS_MCLK_EN |=> o_master_clock_oe == $past(i_wdata[0]))
    else $error("pin enable does not follow written bit");
  a_channel_decode: assert property (
    i_wr && i_addr == OFS_CHANNELS |=>
      o_left_en == ($past(i_wdata[1:0]) != CHAN_RIGHT) &&
      o_right_en == ($past(i_wdata[1:0]) != CHAN_LEFT))
    else $error("channel enables do not match code");
  a_tx_fetch_next: assert property (
    i_tx_req && o_tx_ready |=> o_txm_rd && !o_tx_ready)
    else $error("transmit fetch not issued");
  a_tx_word_aligned: assert property (
    o_txm_rd |-> o_txm_addr[1:0] == 2'b00)
    else $error("transmit fetch not word aligned");
  a_tx_word_pass: assert property (
    i_txm_rvalid |=> o_tx_word_valid && o_tx_word == $past(i_txm_rdata))
    else $error("fetched word not handed on");
  a_rx_word_store: assert property (
    i_rx_word_valid |=> o_rxm_wr && o_rxm_wdata == $past(i_rx_word))
    else $error("received word not written");
endmodule

bind ascc_top ascc_monitor ascc_monitor_i (.i_clk, .i_resetn, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .o_master_clock_out,
  .o_master_clock_oe, .o_left_en, .o_right_en, .i_rx_word_valid,
  .i_rx_word, .o_rxm_wr, .o_rxm_wdata, .i_tx_req, .o_tx_ready,
  .o_tx_word_valid, .o_tx_word, .o_txm_rd, .o_txm_addr, .i_txm_rvalid,
  .i_txm_rdata);

/* File: verification/ascc_mem_model.sv */
// data memory read responder for transmit fetches
// assumes one read outstanding; answers after a varying delay
`timescale 1ns/100ps

module ascc_mem_model (
  // clock
  input  wire logic        i_clk,
  // fetch request
  input  wire logic        i_rd,
  input  wire logic [31:0] i_addr,
  // answer
  output      logic        o_rvalid,
  output      logic [31:0] o_rdata
);
  logic [31:0] req_addr;
  int          wait_cnt = -1;
  int          slow     = 0;

  initial o_rvalid = 1'b0;
  initial o_rdata  = 32'h0;

  always @(posedge i_clk) begin
    o_rvalid <= 1'b0;
    // data line not held outside an answer
    o_rdata  <= ~o_rdata;
    if (i_rd) begin
      // raw address kept so a misaligned fetch gives wrong data
      req_addr <= i_addr;
      wait_cnt <= slow;
      slow     <= (slow + 3) % 7;
    end else if (wait_cnt == 0) begin
      o_rvalid <= 1'b1;
      o_rdata  <= req_addr ^ 32'hA5A5_5A5A;
      wait_cnt <= -1;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule

/* File: verification/test_audio_serial_clock_config.sv */
// self-checking bench for the audio serial configuration block
// assumes the memory responder model and the bound port monitor
`timescale 1ns/100ps

module test_audio_serial_clock_config;
  import ascc_pkg::*;
  logic        i_clk = 0, i_resetn = 0, i_wr = 0, i_rd = 0;
  logic        i_rx_word_valid = 0, i_tx_req = 0, fr_q, mk_q;
  logic [11:0] i_addr = 0;
  logic [31:0] i_wdata = 0, i_rx_word = 0, rs, nb;
  wire  [31:0] i_txm_rdata, o_rdata, o_rxm_addr, o_rxm_wdata;
  wire  [31:0] o_tx_word, o_txm_addr;
  wire         i_txm_rvalid, o_rxm_wr, o_txm_rd, o_tx_word_valid;
  wire         o_master_clock_out, o_master_clock_oe, o_frame_clock;
  wire         o_left_en, o_right_en, o_frame_tick, o_tx_ready;
  wire  [31:0] o_sample_width_setting, o_align_setting, o_format_setting;
  int          n_fail = 0, compares = 0, n, d;
  int          dv[9] = '{32, 48, 64, 96, 128, 192, 256, 384, 512};
  logic [11:0] ofs[9] = '{OFS_MCLK_EN, OFS_MCLK_DIV, OFS_RATIO, OFS_WIDTH,
    OFS_ALIGN, OFS_FORMAT, OFS_CHANNELS, OFS_RX_START, OFS_TX_START};
  logic [31:0] rv[9] = '{32'h1, 32'h2000_0000, 32'h6, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] mk[9] = '{32'h1, '1, 32'hF, '1, '1, '1, 32'h3, 32'hFFFF_FFFC,
    32'hFFFF_FFFC};
  logic [31:0] cd[11] = '{32'h2000_0000, 32'h1800_0000, 32'h1600_0000,
    32'h1100_0000, 32'h1000_0000, 32'h0C00_0000, 32'h0B00_0000,
    32'h0840_0000, 32'h0600_0000, 32'h0410_0000, 32'h020C_0000};

  ascc_top ascc_top_i (.i_clk, .i_resetn, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .o_master_clock_out, .o_master_clock_oe,
    .o_frame_clock, .o_frame_tick, .o_left_en, .o_right_en,
    .o_sample_width_setting, .o_align_setting, .o_format_setting,
    .i_rx_word_valid, .i_rx_word, .o_rxm_wr, .o_rxm_addr, .o_rxm_wdata,
    .i_tx_req, .o_tx_ready, .o_tx_word_valid, .o_tx_word, .o_txm_rd,
    .o_txm_addr, .i_txm_rvalid, .i_txm_rdata);
  ascc_mem_model ascc_mem_model_i (.i_clk, .i_rd(o_txm_rd),
    .i_addr(o_txm_addr), .o_rvalid(i_txm_rvalid), .o_rdata(i_txm_rdata));

  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    fr_q <= o_frame_clock;
    mk_q <= o_master_clock_out;
  end

  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] v);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask

  task automatic rd(logic [11:0] a, logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 chk("rdata", e, o_rdata);
  endtask

  // rise count may differ by one from the ideal phase
  task automatic mclk_run(logic [31:0] c);
    wr(OFS_MCLK_EN, 32'h0);
    rd(OFS_STATUS, 32'h0);
    wr(OFS_MCLK_DIV, c);
    #1 chk("pin enable", 32'h0, o_master_clock_oe);
    chk("mclk idle", 32'h0, o_master_clock_out);
    wr(OFS_MCLK_EN, 32'h1);
    n = 0;
    repeat (2000) begin
      @(posedge i_clk);
      #1 n += o_master_clock_out & ~mk_q;
    end
    d = n - int'((64'(c) * 2000) >> 32);
    chk("mclk rises", 32'h1, d >= -1 && d <= 1);
  endtask

  task automatic frm(int r);
    wr(OFS_RATIO, r);
    repeat (3) begin
      n = 0;
      do begin
        @(posedge i_clk);
        #1 n++;
      end while (!(o_frame_clock & ~fr_q) && n < 9000);
    end
    chk("frame period", dv[r] * 8, n);
    chk("frame tick", 32'h1, o_frame_tick);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h9670_791F));
    repeat (4) @(posedge i_clk);
    i_resetn <= 1'b1;
    foreach (ofs[i])
      rd(ofs[i], rv[i]);
    rd(OFS_WORD_CNT, 32'h0);
    for (int i = 1; i < 9; i++) begin
      nb = $urandom;
      wr(ofs[i], nb);
      rd(ofs[i], nb & mk[i]);
      if (i == 3) chk("width out", nb, o_sample_width_setting);
      if (i == 4) chk("align out", nb, o_align_setting);
      if (i == 5) chk("format out", nb, o_format_setting);
      wr(ofs[i], rv[i]);
    end
    wr(12'h7FC, $urandom);
    rd(12'h7FC, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_CHANNELS, c);
      #1 chk("left", c != 2, o_left_en);
      chk("right", c != 1, o_right_en);
    end
    foreach (cd[i])
      mclk_run(cd[i]);
    mclk_run(DIVIDE_BY_EIGHT_CODE);
    foreach (dv[i])
      frm(i);
    wr(OFS_WORD_CNT, 32'h3);
    nb = $urandom & 32'hFFFF_FFFC;
    wr(OFS_RX_START, nb);
    for (int k = 0; k < 7; k++) begin
      rs = $urandom;
      @(posedge i_clk);
      i_rx_word_valid <= 1'b1;
      i_rx_word       <= rs;
      @(posedge i_clk);
      i_rx_word_valid <= 1'b0;
      #1 chk("rx write", 32'h1, o_rxm_wr);
      chk("rx addr", nb + 4 * (k % 3), o_rxm_addr);
      chk("rx data", rs, o_rxm_wdata);
    end
    rd(OFS_RX_INDEX, 32'h1);
    nb = $urandom;
    wr(OFS_TX_START, nb);
    nb[1:0] = 2'b00;
    for (int k = 0; k < 5; k++) begin
      @(posedge i_clk);
      i_tx_req <= 1'b1;
      @(posedge i_clk);
      i_tx_req <= 1'b0;
      #1 chk("tx busy", 32'h0, o_tx_ready);
      n = 0;
      do begin
        @(posedge i_clk);
        #1 n++;
      end while (o_tx_word_valid !== 1'b1 && n < 50);
      rs = nb + 4 * (k % 3);
      chk("tx addr", rs, o_txm_addr);
      chk("tx word", rs ^ 32'hA5A5_5A5A, o_tx_word);
      chk("tx valid", 32'h1, o_tx_word_valid);
      chk("tx ready", 32'h1, o_tx_ready);
    end
    rd(OFS_TX_INDEX, 32'h2);
    print_verdict;
  end

  initial begin
    #3800000;
    n_fail++;
    print_verdict;
  end
endmodule
